// ==== include/vip_pkg.sv ====
/*
 * Constants, register map and mode encoding for the vectored interrupt unit.
 * Assumes a 32-bit APB master and a 16-bit core that supplies its PC.
 */
`default_nettype none
package vip_pkg;
    localparam int          VIP_NSRC     = 8;
    localparam logic [7:0]  VIP_OFS_EN   = 8'h00;
    localparam logic [7:0]  VIP_OFS_PEND = 8'h04;
    localparam logic [7:0]  VIP_OFS_COND = 8'h08;
    localparam logic [7:0]  VIP_OFS_HEN  = 8'h0C;
    localparam logic [7:0]  VIP_OFS_PWR  = 8'h10;
    localparam logic [7:0]  VIP_OFS_SP   = 8'h14;
    localparam logic [7:0]  VIP_OFS_STS  = 8'h18;
    localparam logic [7:0]  VIP_OFS_MASK = 8'h1C;
    localparam int          VIP_GIE_BIT  = 0;
    localparam int          VIP_PWR_IDLE = 0;
    localparam int          VIP_PWR_HALT = 1;
    localparam logic [15:0] VIP_VEC_TOP  = 16'hFFFE;
    localparam logic [15:0] VIP_SP_STEP  = 16'h0002;
    localparam logic [15:0] VIP_SP_RST   = 16'h0000;
    localparam logic [7:0]  VIP_EN_RST   = 8'h00;
    localparam logic [3:0]  VIP_MASK_RST = 4'h0;
    typedef enum logic [1:0] {
        VIP_RUN  = 2'b00,
        VIP_IDLE = 2'b01,
        VIP_HALT = 2'b10
    } vip_mode_t;
endpackage
`default_nettype wire

// ==== hdl/vip_top.sv ====
/*
 * Vectored interrupt unit: eight ranked sources, pending/enable/polarity
 * registers, acknowledge and vector sequencing, reset vectoring, DMA stop
 * on the nonmaskable input, idle and halt power modes, APB register slave.
 * Assumes all inputs are synchronous to sys_clk except the four external
 * interrupt pins and the reset request pin, which are synchronised here.
 */
// Summary of operation
// - Eight sources, rank 0 reset at FFFE down to rank 7 end-of-message at FFF0.
// - Simultaneous requests are arbitrated so exactly one source is serviced.
// - Service starts only after the current instruction; reset acts at once.
// - Reset request is a level; other pins are edges; pins 2, 3 and 4 edge selectable.
// - Condition register holds polarity bits for external pins 2, 3 and 4.
// - Reset and nonmaskable always served; others need own and global enable.
// - One pending bit per vector, set even if disabled; register is read/write.
// - Hardware clears pending bits of sources 0..3 on service; software clears pin 4 and peripherals.
// - Acknowledge pushes PC, advances SP by two, clears global enable, loads vector.
// - Return pops PC and sets global enable; handlers may set it to nest.
// - Nonmaskable input stops DMA after the byte in progress; HDLC keeps running.
// - Reset floats ports except high byte enable, then fetches the top vector.
// - Idle resumes on timer overflow, reset or nonmaskable input.
// - Halt exits only by reset or nonmaskable input, the latter vectored.
// - Halt-enable register takes one write after reset; later writes ignored.
`default_nettype none
module vip_top
    import vip_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        ext_reset_n,
    input  wire logic        nmi_pin,
    input  wire logic        ext_irq_pin_2,
    input  wire logic        ext_irq_pin_3,
    input  wire logic        ext_irq_pin_4,
    input  wire logic        hdlc_dma_err,
    input  wire logic        timer_irq,
    input  wire logic        uart_irq,
    input  wire logic        end_of_message_irq,
    input  wire logic        free_running_timer_ovf,
    input  wire logic        instr_done,
    input  wire logic        return_from_irq_instr,
    input  wire logic [15:0] cpu_pc,
    input  wire logic        dma_byte_busy,
    output logic             cpu_ack,
    output logic [15:0]      vector_addr,
    output logic             stack_push,
    output logic             stack_pop,
    output logic [15:0]      stack_addr,
    output logic [15:0]      stack_wdata,
    output logic             cpu_reset,
    output logic             port_hiz,
    output logic             cpu_stall,
    output logic             clk_stop,
    output logic             dma_halt,
    output logic             irq
);

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  prev;
        logic        rq1;
        logic        rq2;
        logic        boot;
        logic [7:0]  en;
        logic [7:0]  pend;
        logic [2:0]  cond;
        logic        halt_en;
        logic        he_lock;
        vip_mode_t   mode;
        logic [15:0] sp;
        logic [3:0]  sts;
        logic [3:0]  mask;
        logic        nmi_act;
        logic        dma_req;
        logic        dma_halt;
        logic        irq;
        logic        ack;
        logic        push;
        logic        pop;
        logic [15:0] vec;
        logic [15:0] saddr;
        logic [15:0] sdata;
        logic        cpu_rst;
        logic        hiz;
        logic        stall;
        logic        cstop;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } vip_state_t;

    vip_state_t s_r;
    vip_state_t s_nxt;

    logic [3:0]  rise;
    logic [3:0]  fall;
    logic [3:0]  edg;
    logic [7:0]  set;
    logic [7:0]  req;
    logic [7:0]  svc_clr;
    logic [7:0]  pbase;
    logic [2:0]  sel;
    logic        start;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [31:0] rdv;
    logic [3:0]  ev;
    logic        wake;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.push = 1'b0;
        s_nxt.pop = 1'b0;
        // Pin 4 shares the polarity scheme with 2 and 3
        s_nxt.sync1 = {ext_irq_pin_4, ext_irq_pin_3, ext_irq_pin_2, nmi_pin};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        s_nxt.rq1 = ext_reset_n;
        s_nxt.rq2 = s_r.rq1;
        rise = s_r.sync2 & ~s_r.prev;
        fall = ~s_r.sync2 & s_r.prev;
        edg[0] = rise[0];
        for (int k = 1; k < 4; k++) begin
            edg[k] = s_r.cond[k-1] ? rise[k] : fall[k];
        end
        // Reset is a level; pending stays set while the pin is low
        set = {end_of_message_irq, uart_irq, timer_irq,
               edg[3] | hdlc_dma_err, edg[2], edg[1], edg[0], ~s_r.rq2};
        req = s_r.pend & {s_r.en[7:2] & {6{s_r.en[VIP_GIE_BIT]}}, 2'b11};
        sel = 3'd0;
        for (int k = VIP_NSRC - 1; k >= 0; k--) begin
            if (req[k]) begin
                sel = k[2:0];
            end
        end
        // Only the nonmaskable source may start service while idle or halted
        start = (|req) && ((s_r.mode == VIP_RUN && instr_done) ||
                           (s_r.mode != VIP_RUN && req[1]));
        wake = 1'b0;

        acc = psel & penable;
        wr = acc & s_r.pready & pwrite;
        rd = acc & s_r.pready & ~pwrite;
        s_nxt.pready = acc & ~s_r.pready;
        hit = 1'b1;
        rdv = 32'h0000_0000;
        case (paddr)
            VIP_OFS_EN: rdv[7:0] = s_r.en;
            VIP_OFS_PEND: rdv[7:0] = s_r.pend;
            VIP_OFS_COND: rdv[2:0] = s_r.cond;
            VIP_OFS_HEN: rdv[1:0] = {s_r.he_lock, s_r.halt_en};
            VIP_OFS_PWR: rdv[1:0] = s_r.mode;
            VIP_OFS_SP: rdv[15:0] = s_r.sp;
            VIP_OFS_STS: rdv[3:0] = s_r.sts;
            VIP_OFS_MASK: rdv[3:0] = s_r.mask;
            default: hit = 1'b0;
        endcase
        if (acc && !s_r.pready) begin
            s_nxt.prdata = rdv;
            s_nxt.pslverr = ~hit;
        end

        ev = 4'h0;
        if (wr) begin
            unique case (paddr)
                VIP_OFS_EN: s_nxt.en = pwdata[7:0];
                VIP_OFS_COND: s_nxt.cond = pwdata[2:0];
                VIP_OFS_SP: s_nxt.sp = pwdata[15:0];
                VIP_OFS_MASK: s_nxt.mask = pwdata[3:0];
                VIP_OFS_HEN: begin
                    if (!s_r.he_lock) begin
                        s_nxt.halt_en = pwdata[0];
                        s_nxt.he_lock = 1'b1;
                    end else begin
                        ev[2] = 1'b1;
                    end
                end
                VIP_OFS_PWR: begin
                    if (s_r.mode == VIP_RUN) begin
                        if (pwdata[VIP_PWR_HALT] && s_r.halt_en) begin
                            s_nxt.mode = VIP_HALT;
                        end else if (pwdata[VIP_PWR_IDLE]) begin
                            s_nxt.mode = VIP_IDLE;
                        end
                    end
                end
                default: ;
            endcase
        end
        pbase = (wr && paddr == VIP_OFS_PEND) ? pwdata[7:0] : s_r.pend;

        // Return from handler pops and re-enables
        if (return_from_irq_instr) begin
            s_nxt.pop = 1'b1;
            s_nxt.saddr = s_r.sp - VIP_SP_STEP;
            s_nxt.sp = s_r.sp - VIP_SP_STEP;
            s_nxt.en[VIP_GIE_BIT] = 1'b1;
            if (s_r.nmi_act) begin
                s_nxt.nmi_act = 1'b0;
                s_nxt.dma_req = 1'b0;
            end
        end

        unique case (s_r.mode)
            VIP_RUN: ;
            VIP_IDLE: begin
                if (free_running_timer_ovf || edg[0]) begin
                    s_nxt.mode = VIP_RUN;
                    wake = 1'b1;
                end
            end
            VIP_HALT: begin
                if (edg[0]) begin
                    s_nxt.mode = VIP_RUN;
                    wake = 1'b1;
                end
            end
            default: s_nxt.mode = VIP_RUN;
        endcase

        svc_clr = 8'h00;
        if (!s_r.rq2) begin
            // Immediate reset: core held, ports floated
            s_nxt.cpu_rst = 1'b1;
            s_nxt.hiz = 1'b1;
            s_nxt.boot = 1'b1;
            s_nxt.en = VIP_EN_RST;
            s_nxt.mode = VIP_RUN;
            s_nxt.nmi_act = 1'b0;
            s_nxt.dma_req = 1'b0;
            wake = 1'b0;
        end else if (s_r.boot) begin
            s_nxt.boot = 1'b0;
            s_nxt.cpu_rst = 1'b0;
            s_nxt.hiz = 1'b0;
            s_nxt.ack = 1'b1;
            s_nxt.vec = VIP_VEC_TOP;
            svc_clr[0] = 1'b1;
        end else if (start) begin
            s_nxt.ack = 1'b1;
            s_nxt.vec = VIP_VEC_TOP - {12'h000, sel, 1'b0};
            s_nxt.push = 1'b1;
            s_nxt.saddr = s_r.sp;
            s_nxt.sdata = cpu_pc;
            s_nxt.sp = s_r.sp + VIP_SP_STEP;
            s_nxt.en[VIP_GIE_BIT] = 1'b0;
            // Peripheral sources 4..7 stay pending for software
            svc_clr[sel] = (sel < 3'd4);
            if (sel == 3'd1) begin
                s_nxt.nmi_act = 1'b1;
            end
            if (s_r.mode != VIP_RUN) begin
                s_nxt.mode = VIP_RUN;
            end
        end
        if (edg[0] && s_r.rq2) begin
            s_nxt.dma_req = 1'b1;
        end
        // DMA stops only once the byte in flight has finished
        s_nxt.dma_halt = s_nxt.dma_req & (s_r.dma_halt | ~dma_byte_busy);
        s_nxt.pend = (pbase & ~svc_clr) | set;

        ev[0] = s_nxt.ack;
        ev[1] = wake;
        ev[3] = s_nxt.dma_halt & ~s_r.dma_halt;
        // New events win over the read that clears the register
        s_nxt.sts = ((rd && paddr == VIP_OFS_STS) ? 4'h0 : s_r.sts) | ev;
        s_nxt.irq = |(s_nxt.sts & s_r.mask);
        // Registered decodes of the next mode keep both core pins glitch free
        s_nxt.stall = (s_nxt.mode != VIP_RUN);
        s_nxt.cstop = (s_nxt.mode == VIP_HALT);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.rq1 <= 1'b0;
            s_r.boot <= 1'b1;
            s_r.en <= VIP_EN_RST;
            s_r.mode <= VIP_RUN;
            s_r.sp <= VIP_SP_RST;
            s_r.mask <= VIP_MASK_RST;
            s_r.cpu_rst <= 1'b1;
            s_r.hiz <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready = s_r.pready;
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr;
    assign cpu_ack = s_r.ack;
    assign vector_addr = s_r.vec;
    assign stack_push = s_r.push;
    assign stack_pop = s_r.pop;
    assign stack_addr = s_r.saddr;
    assign stack_wdata = s_r.sdata;
    assign cpu_reset = s_r.cpu_rst;
    assign port_hiz = s_r.hiz;
    assign cpu_stall = s_r.stall;
    assign clk_stop = s_r.cstop;
    assign dma_halt = s_r.dma_halt;
    assign irq = s_r.irq;

    a_edge_pend: assert property (@(posedge sys_clk) disable iff (rst)
        (edg[1] && !wr) |=> s_r.pend[2])
        else $error("pin 2 edge did not set pending");

    a_ack_push: assert property (@(posedge sys_clk) disable iff (rst)
        (start && s_r.rq2 && !s_r.boot && !return_from_irq_instr && !wr)
        |=> stack_push && !s_r.en[VIP_GIE_BIT] && s_r.sp == $past(s_r.sp) + VIP_SP_STEP)
        else $error("acknowledge did not push and disable");

    a_return_from_irq_instr_gie: assert property (@(posedge sys_clk) disable iff (rst)
        (return_from_irq_instr && !start && s_r.rq2 && !s_r.boot && !wr)
        |=> s_r.en[VIP_GIE_BIT] && stack_pop)
        else $error("return did not re-enable");

    a_instr_wait: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.mode == VIP_RUN && !instr_done && !s_r.boot) |=> !cpu_ack)
        else $error("service began mid instruction");

    a_mask_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (!s_r.en[VIP_GIE_BIT] && s_r.pend[1:0] == 2'b00 && !s_r.boot) |=> !cpu_ack)
        else $error("masked source serviced");

    a_prio_low: assert property (@(posedge sys_clk) disable iff (rst)
        (start && req[1] && !req[0] && s_r.rq2 && !s_r.boot) |=> vector_addr == 16'hFFFC)
        else $error("nmi lost arbitration");

    a_nmi_dma: assert property (@(posedge sys_clk) disable iff (rst)
        (edg[0] && s_r.rq2) ##1 !dma_byte_busy |=> dma_halt)
        else $error("dma not halted after nmi");

    a_reset_hiz: assert property (@(posedge sys_clk) disable iff (rst)
        !s_r.rq2 |=> port_hiz && cpu_reset ##1 (s_r.rq2 || port_hiz))
        else $error("reset did not float ports");

    a_halt_once: assert property (@(posedge sys_clk) disable iff (rst)
        (wr && paddr == VIP_OFS_HEN && s_r.he_lock && s_r.rq2) |=> $stable(s_r.halt_en))
        else $error("halt enable rewritten");

    a_halt_exit: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_stop && !edg[0] && s_r.rq2) |=> clk_stop)
        else $error("halt left without nmi or reset");

    a_idle_wake: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.mode == VIP_IDLE && free_running_timer_ovf && s_r.rq2) |=> !cpu_stall)
        else $error("idle not left on timer overflow");

    a_ext_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (start && s_r.rq2 && !s_r.boot && sel == 3'd2 && !set[2] && !wr) |=> !s_r.pend[2])
        else $error("serviced pin 2 left pending");

    a_boot_vec: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.boot && s_r.rq2) |=> cpu_ack && vector_addr == VIP_VEC_TOP && !port_hiz)
        else $error("boot vector not fetched");

endmodule // vip_top
`default_nettype wire

// ==== test/vip_core_model.sv ====
/*
 * Core model: finishes instructions, jumps to 8000 on each acknowledge and runs returns.
 * Assumes the bench asks for each return and may hold instructions back.
 */
`default_nettype none
module vip_core_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hold,
    input  wire logic        do_ret,
    input  wire logic        cpu_ack,
    input  wire logic        cpu_stall,
    input  wire logic        cpu_reset,
    output logic             instr_done,
    output logic             return_from_irq_instr,
    output logic [15:0]      cpu_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            instr_done            <= 1'b0;
            return_from_irq_instr <= 1'b0;
            cpu_pc                <= 16'h1000;
        end else begin
            // A held core stands for a long instruction, so no service yet
            instr_done            <= !hold && !cpu_stall && !cpu_reset;
            // Handler ends only when the bench says so
            return_from_irq_instr <= do_ret;
            if (cpu_ack)
                cpu_pc <= 16'h8000;
            else if (instr_done)
                cpu_pc <= cpu_pc + 16'h0002;
        end
    end
endmodule // vip_core_model
`default_nettype wire

// ==== test/tb_top.sv ====
/*
 * Bench for the vectored interrupt unit: APB traffic, pin and peripheral
 * events, service and return, DMA stop, power modes, reset requests.
 * Assumes the core model shares sys_clk and rst with the unit.
 */
`default_nettype none
module tb_top
    import vip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, ext_reset_n, nmi_pin, tovf;
    logic        busy, rerr, hold, do_ret, instr_done, ret, cpu_ack, stack_push, idone_q;
    logic        stack_pop, cpu_reset, port_hiz, cpu_stall, clk_stop, dma_halt, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0]  xpin;
    logic [3:0]  src;
    logic [15:0] cpu_pc, vector_addr, stack_addr, stack_wdata, pc_q, sp_exp, lfsr;
    int          err_count, checked, ack_cnt, cyc, n, r, a0;

    always #4 sys_clk = ~sys_clk;

    vip_top i_vip_top (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .ext_reset_n, .nmi_pin, .ext_irq_pin_2(xpin[0]),
        .ext_irq_pin_3(xpin[1]), .ext_irq_pin_4(xpin[2]), .hdlc_dma_err(src[0]),
        .timer_irq(src[1]), .uart_irq(src[2]), .end_of_message_irq(src[3]),
        .free_running_timer_ovf(tovf), .instr_done, .return_from_irq_instr(ret), .cpu_pc,
        .dma_byte_busy(busy), .cpu_ack, .vector_addr, .stack_push, .stack_pop, .stack_addr,
        .stack_wdata, .cpu_reset, .port_hiz, .cpu_stall, .clk_stop, .dma_halt, .irq);
    vip_core_model i_vip_core_model (.sys_clk, .rst, .hold, .do_ret, .cpu_ack, .cpu_stall,
        .cpu_reset, .instr_done, .return_from_irq_instr(ret), .cpu_pc);

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following setup never lands in the same time step
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic wait_ack(input logic [15:0] v, input logic p);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (cpu_ack !== 1'b1 && n < 60);
        chk("ack", 32'h1, 32'(cpu_ack));
        chk("vector", 32'(v), 32'(vector_addr));
        if (p) begin
            chk("push", 32'h1, 32'(stack_push));
            chk("push addr", 32'(sp_exp), 32'(stack_addr));
            chk("push data", 32'(pc_q), 32'(stack_wdata));
            sp_exp += 16'h0002;
        end
    endtask
    task automatic ret_irq();
        do_ret <= 1'b1;
        @(posedge sys_clk);
        do_ret <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (stack_pop !== 1'b1 && n < 20);
        chk("pop", 32'h1, 32'(stack_pop));
        sp_exp -= 16'h0002;
        chk("pop addr", 32'(sp_exp), 32'(stack_addr));
    endtask
    task automatic pulse_ovf();
        tovf <= 1'b1;
        tick(1);
        tovf <= 1'b0;
        tick(3);
    endtask

    always @(posedge sys_clk) begin
        pc_q    <= cpu_pc;
        idone_q <= instr_done;
        if (cpu_ack === 1'b1)
            ack_cnt <= ack_cnt + 1;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        {psel, penable, pwrite, nmi_pin, tovf, busy, hold, do_ret} <= 8'h00;
        paddr       <= 8'h00;
        pwdata      <= 32'h0;
        xpin        <= 3'h0;
        src         <= 4'h0;
        ext_reset_n <= 1'b1;
        lfsr = 16'hFE85;
        tick(2);
        chk("rst out", 32'h1, 32'(cpu_reset));
        chk("rst hiz", 32'h1, 32'(port_hiz));
        rst <= 1'b0;
        wait_ack(VIP_VEC_TOP, 1'b0);
        tick(1);
        chk("run hiz", 32'h0, 32'(port_hiz));
        rd("en rst", VIP_OFS_EN, 32'(VIP_EN_RST));
        rd("sp rst", VIP_OFS_SP, 32'(VIP_SP_RST));
        rd("unmapped", 8'h20, 32'h0);
        chk("slverr", 32'h1, 32'(rerr));
        lfsr = lfsr_next(lfsr);
        sp_exp = lfsr & 16'hFFFE;
        wr(VIP_OFS_SP, 32'(sp_exp));
        // Each pin, each polarity; the opposite edge must leave pending clear
        for (r = 0; r < 6; r++) begin
            xpin <= {3{!r[0]}};
            wr(VIP_OFS_COND, {29'h0, {3{r[0]}}});
            tick(4);
            wr(VIP_OFS_PEND, 32'h0);
            xpin[r / 2] <= r[0];
            tick(4);
            rd("edge", VIP_OFS_PEND, 32'h4 << (r / 2));
            wr(VIP_OFS_PEND, 32'h0);
            xpin[r / 2] <= !r[0];
            tick(4);
            rd("wrong edge", VIP_OFS_PEND, 32'h0);
        end
        hold <= 1'b1;
        xpin <= 3'h0;
        wr(VIP_OFS_COND, 32'h7);
        wr(VIP_OFS_MASK, 32'h1);
        wr(VIP_OFS_PEND, 32'h0);
        wr(VIP_OFS_EN, 32'h0D);
        a0 = ack_cnt;
        xpin <= 3'h3;
        tick(8);
        chk("held", 32'(a0), 32'(ack_cnt));
        hold <= 1'b0;
        wait_ack(VIP_VEC_TOP - 16'h0004, 1'b1);
        chk("after instr", 32'h1, 32'(idone_q));
        rd("gie clr", VIP_OFS_EN, 32'h0C);
        rd("sp push", VIP_OFS_SP, 32'(sp_exp));
        rd("ext clr", VIP_OFS_PEND, 32'h08);
        chk("no nest", 32'(a0 + 1), 32'(ack_cnt));
        chk("irq", 32'h1, 32'(irq));
        rd("status", VIP_OFS_STS, 32'h1);
        tick(2);
        chk("irq clr", 32'h0, 32'(irq));
        ret_irq();
        wait_ack(VIP_VEC_TOP - 16'h0006, 1'b1);
        rd("pend empty", VIP_OFS_PEND, 32'h0);
        ret_irq();
        wr(VIP_OFS_MASK, 32'h0);
        for (r = 4; r < 8; r++) begin
            hold <= 1'b1;
            wr(VIP_OFS_EN, 32'h1 << r);
            a0 = ack_cnt;
            lfsr = lfsr_next(lfsr);
            src[r - 4] <= 1'b1;
            tick(1 + lfsr[1:0]);
            src <= 4'h0;
            tick(3);
            hold <= 1'b0;
            tick(3);
            chk("no gie", 32'(a0), 32'(ack_cnt));
            rd("periph", VIP_OFS_PEND, 32'h1 << r);
            hold <= 1'b1;
            wr(VIP_OFS_EN, (32'h1 << r) | 32'h1);
            hold <= 1'b0;
            wait_ack(VIP_VEC_TOP - 16'(2 * r), 1'b1);
            rd("sw clear", VIP_OFS_PEND, 32'h1 << r);
            wr(VIP_OFS_PEND, 32'h0);
            chk("irq masked", 32'h0, 32'(irq));
            ret_irq();
        end
        hold <= 1'b1;
        wr(VIP_OFS_EN, 32'h0);
        busy <= 1'b1;
        nmi_pin <= 1'b1;
        tick(6);
        chk("dma byte", 32'h0, 32'(dma_halt));
        busy <= 1'b0;
        tick(3);
        chk("dma halt", 32'h1, 32'(dma_halt));
        hold <= 1'b0;
        wait_ack(VIP_VEC_TOP - 16'h0002, 1'b1);
        ret_irq();
        nmi_pin <= 1'b0;
        tick(3);
        chk("dma go", 32'h0, 32'(dma_halt));
        wr(VIP_OFS_PWR, 32'h1);
        tick(2);
        chk("idle", 32'h1, 32'(cpu_stall));
        a0 = ack_cnt;
        pulse_ovf();
        chk("wake", 32'h0, 32'(cpu_stall));
        chk("no vec", 32'(a0), 32'(ack_cnt));
        wr(VIP_OFS_HEN, 32'h1);
        wr(VIP_OFS_HEN, 32'h0);
        apb(1'b0, VIP_OFS_HEN, 32'h0);
        chk("hen kept", 32'h1, 32'(rdat[0]));
        apb(1'b0, VIP_OFS_STS, 32'h0);
        chk("hen refused", 32'h1, 32'(rdat[2]));
        wr(VIP_OFS_PWR, 32'h2);
        pulse_ovf();
        chk("halt", 32'h1, 32'(clk_stop));
        nmi_pin <= 1'b1;
        wait_ack(VIP_VEC_TOP - 16'h0002, 1'b1);
        chk("no reinit", 32'h0, 32'(cpu_reset));
        tick(2);
        chk("halt exit", 32'h0, 32'(clk_stop));
        ret_irq();
        nmi_pin <= 1'b0;
        ext_reset_n <= 1'b0;
        tick(5);
        chk("pin rst", 32'h1, 32'(cpu_reset));
        chk("pin hiz", 32'h1, 32'(port_hiz));
        rd("en clr", VIP_OFS_EN, 32'h0);
        ext_reset_n <= 1'b1;
        wait_ack(VIP_VEC_TOP, 1'b0);
        final_report();
    end
endmodule // tb_top
`default_nettype wire
